/* File: hdl/irq_entry_pkg.sv */
// constants and types shared by the interrupt entry sequencer
package irq_entry_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_FLAG = 8'h00;
    localparam logic [7:0] ADDR_PEND = 8'h04;
    localparam logic [7:0] ADDR_LEVEL = 8'h08;
    localparam logic [7:0] ADDR_PC = 8'h0C;
    localparam logic [7:0] ADDR_ISP = 8'h10;
    localparam logic [7:0] ADDR_USP = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_TIMING = 8'h1C;
    // flag word fields
    localparam int FLAG_D_BIT = 2;
    localparam int FLAG_I_BIT = 6;
    localparam int FLAG_U_BIT = 7;
    localparam int PRIO_LSB = 12;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    // fixed-source pending bit positions in the pending register
    localparam int PEND_NMI = 16;
    localparam int PEND_BRK = 17;
    localparam int PEND_WDT = 18;
    localparam int PEND_SS = 19;
    localparam int PEND_AM = 20;
    // bus address of the interrupt information read
    localparam logic [19:0] INFO_ADDR = 20'h00000;
    // entry timing in cycles
    localparam logic [4:0] CYC_EVEN = 5'h12;
    localparam logic [4:0] CYC_BUS8 = 5'h14;
    localparam logic [4:0] CYC_BRK_EXTRA = 5'h02;
    localparam logic [4:0] CYC_SS_AM_EXTRA = 5'h01;
    localparam logic [4:0] CYC_PUSH_START = 5'h03;
    localparam logic [4:0] WAIT_MAX = 5'h1E;
    // priority levels loaded on entry
    localparam logic [2:0] PRIO_NMI_WDT = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h0;
    // software interrupt numbers that keep the stack select flag
    localparam logic [5:0] SWI_KEEP_U_LO = 6'h20;
    localparam logic [5:0] SWI_KEEP_U_HI = 6'h3F;
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000, SRC_NMI = 3'b001, SRC_BRK = 3'b010, SRC_WDT = 3'b011,
        SRC_PERIPH = 3'b100, SRC_SS = 3'b101, SRC_AM = 3'b110, SRC_SWI = 3'b111
    } src_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000, ST_ENTRY = 3'b001, ST_RET_LO = 3'b010,
        ST_RET_HI = 3'b011, ST_RET_END = 3'b100
    } state_t;
endpackage

/* File: hdl/interrupt_entry_sequencer.sv */
// interrupt acceptance, entry sequence, stacking and return for the cpu core
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module interrupt_entry_sequencer
#(
    parameter int NUM_PERIPH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources, one-cycle pulses
    input wire logic [NUM_PERIPH-1:0] periph_req,
    input wire logic nmi_req,
    input wire logic debugger_break_request,
    input wire logic wdt_req,
    input wire logic single_step_req,
    input wire logic addr_match_req,
    // core instruction status
    input wire logic instr_done,
    input wire logic instr_busy,
    input wire logic instr_suspendable,
    input wire logic swi_exec,
    input wire logic [5:0] swi_num,
    input wire logic return_from_handler_instr,
    input wire logic bus_8bit,
    input wire logic vector_odd,
    input wire logic [19:0] handler_addr,
    // stack and information bus
    output logic mem_we,
    output logic mem_re,
    output logic mem_byte,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    // handler start
    output logic handler_start,
    output irq_entry_pkg::src_t accepted_src,
    output logic [2:0] processor_priority_level
);
    import irq_entry_pkg::*;

    state_t state_reg;
    src_t src_reg;
    logic [15:0] flag_word, temp_flag_reg;
    logic [19:0] pc_reg;
    logic [15:0] isp_reg, usp_reg;
    logic [NUM_PERIPH-1:0] pend_reg;
    logic [4:0] fixed_pend_reg;
    logic [3*NUM_PERIPH-1:0] level_reg;
    logic [4:0] cnt_reg, wait_reg, max_wait_reg, last_len_reg;
    logic overrun_reg, keep_u_reg;
    logic [7:0] per_idx_reg;
    logic [2:0] per_lvl_reg;

    // apb decode; every access completes in its first access cycle
    wire wr_en = psel & penable & pwrite;
    wire hit_flag = paddr == ADDR_FLAG;
    wire hit_pend = paddr == ADDR_PEND;
    wire hit_level = paddr == ADDR_LEVEL;
    wire hit_pc = paddr == ADDR_PC;
    wire hit_isp = paddr == ADDR_ISP;
    wire hit_usp = paddr == ADDR_USP;
    wire hit_status = paddr == ADDR_STATUS;
    wire hit_timing = paddr == ADDR_TIMING;
    wire mapped = hit_flag | hit_pend | hit_level | hit_pc | hit_isp | hit_usp
        | hit_status | hit_timing;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    wire [31:0] pend_word = {11'h000, fixed_pend_reg, {(16 - NUM_PERIPH){1'b0}}, pend_reg};
    assign prdata = hit_flag ? {16'h0000, flag_word}
        : hit_pend ? pend_word
        : hit_level ? {{(32 - 3*NUM_PERIPH){1'b0}}, level_reg}
        : hit_pc ? {12'h000, pc_reg}
        : hit_isp ? {16'h0000, isp_reg}
        : hit_usp ? {16'h0000, usp_reg}
        : hit_status ? {per_idx_reg, 16'h0000, overrun_reg, src_reg, 1'b0, state_reg}
        : hit_timing ? {17'h00000, last_len_reg, 5'h00, max_wait_reg}
        : 32'h0000_0000;

    wire i_flag = flag_word[FLAG_I_BIT];
    wire u_flag = flag_word[FLAG_U_BIT];
    assign processor_priority_level = flag_word[PRIO_LSB+:3];

    // peripheral arbitration: the highest level wins, equal levels go to the lower index
    logic [2:0] best_lvl;
    logic [7:0] best_idx;
    logic best_ok;
    always_comb begin
        best_lvl = 3'h0;
        best_idx = 8'h00;
        best_ok = 1'b0;
        for (int i = NUM_PERIPH - 1; i >= 0; i--) begin
            if (pend_reg[i] && level_reg[3*i+:3] > processor_priority_level &&
                level_reg[3*i+:3] >= best_lvl) begin
                best_lvl = level_reg[3*i+:3];
                best_idx = 8'(i);
                best_ok = 1'b1;
            end
        end
    end
    wire per_ok = best_ok & i_flag;

    // fixed hardware order; reset is presetn itself and outranks all
    wire src_t pick = fixed_pend_reg[0] ? SRC_NMI
        : fixed_pend_reg[1] ? SRC_BRK
        : fixed_pend_reg[2] ? SRC_WDT
        : per_ok ? SRC_PERIPH
        : fixed_pend_reg[3] ? SRC_SS
        : fixed_pend_reg[4] ? SRC_AM
        : SRC_NONE;
    // a normal instruction is judged at its end, a block instruction at once
    wire boundary = instr_done | (instr_busy & instr_suspendable);
    wire in_run = state_reg == ST_RUN;
    wire take_swi = in_run & swi_exec;
    wire take_hw = in_run & ~swi_exec & boundary & (pick != SRC_NONE);
    wire accept = take_swi | take_hw;
    wire ack_info = (state_reg == ST_ENTRY) & (cnt_reg == 5'h00);

    // active stack pointer picked by the current stack-select flag
    wire [15:0] sp = u_flag ? usp_reg : isp_reg;
    wire sp_odd = sp[0];
    wire [4:0] base_len = bus_8bit ? CYC_BUS8
        : CYC_EVEN + {4'h0, vector_odd} + {4'h0, sp_odd};
    wire [4:0] extra_len = (src_reg == SRC_BRK) ? CYC_BRK_EXTRA
        : (src_reg == SRC_SS || src_reg == SRC_AM) ? CYC_SS_AM_EXTRA : 5'h00;
    wire [4:0] entry_len = base_len + extra_len;
    wire entry_last = (state_reg == ST_ENTRY) & (cnt_reg == entry_len - 5'h01);

    // push schedule; only the combined flag halfword and pc low are stacked
    wire [4:0] pstep = cnt_reg - CYC_PUSH_START;
    wire pushing = (state_reg == ST_ENTRY) & (cnt_reg >= CYC_PUSH_START)
        & (pstep < (sp_odd ? 5'h04 : 5'h02));
    wire second_val = sp_odd ? pstep[1] : pstep[0];
    wire [15:0] push_val = second_val ? pc_reg[15:0]
        : {pc_reg[19:16], temp_flag_reg[15:12], temp_flag_reg[7:0]};
    wire [15:0] push_base = sp - (second_val ? 16'h0004 : 16'h0002);
    wire hi_byte = sp_odd & ~pstep[0];
    assign mem_we = pushing;
    assign mem_byte = pushing & sp_odd;
    assign mem_re = ack_info | state_reg == ST_RET_LO | state_reg == ST_RET_HI;
    assign mem_addr = ack_info ? INFO_ADDR
        : pushing ? {4'h0, push_base + {15'h0000, hi_byte}}
        : {4'h0, sp + (state_reg == ST_RET_HI ? 16'h0002 : 16'h0000)};
    assign mem_wdata = ~pushing ? 16'h0000
        : ~sp_odd ? push_val
        : hi_byte ? {8'h00, push_val[15:8]} : {8'h00, push_val[7:0]};
    assign handler_start = entry_last;
    assign accepted_src = src_reg;

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_RUN;
            cnt_reg <= 5'h00;
            src_reg <= SRC_NONE;
            keep_u_reg <= 1'b0;
            per_idx_reg <= 8'h00;
            per_lvl_reg <= 3'h0;
            last_len_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    cnt_reg <= 5'h00;
                    if (accept) begin
                        state_reg <= ST_ENTRY;
                        src_reg <= take_swi ? SRC_SWI : pick;
                        keep_u_reg <= take_swi && swi_num >= SWI_KEEP_U_LO
                            && swi_num <= SWI_KEEP_U_HI;
                        per_idx_reg <= best_idx;
                        per_lvl_reg <= best_lvl;
                    end else if (return_from_handler_instr) begin
                        state_reg <= ST_RET_LO;
                    end
                end
                ST_ENTRY: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (entry_last) begin
                        state_reg <= ST_RUN;
                        last_len_reg <= entry_len;
                    end
                end
                ST_RET_LO: state_reg <= ST_RET_HI;
                ST_RET_HI: state_reg <= ST_RET_END;
                ST_RET_END: state_reg <= ST_RUN;
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // flag word, hidden temporary and program counter
    wire [2:0] prio_next = (src_reg == SRC_PERIPH) ? per_lvl_reg
        : (src_reg == SRC_NMI || src_reg == SRC_WDT) ? PRIO_NMI_WDT
        : processor_priority_level;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_word <= FLAG_RESET;
            temp_flag_reg <= 16'h0000;
            pc_reg <= 20'h00000;
        end else begin
            if (state_reg == ST_ENTRY && cnt_reg == 5'h01)
                temp_flag_reg <= flag_word;
            if (state_reg == ST_ENTRY && cnt_reg == 5'h02) begin
                flag_word[FLAG_I_BIT] <= 1'b0;
                flag_word[FLAG_D_BIT] <= 1'b0;
                if (!keep_u_reg)
                    flag_word[FLAG_U_BIT] <= 1'b0;
            end else if (entry_last) begin
                flag_word[PRIO_LSB+:3] <= prio_next;
            end else if (state_reg == ST_RET_END) begin
                flag_word <= {mem_rdata[11:8], flag_word[11:8], mem_rdata[7:0]};
            end else if (wr_en && hit_flag && in_run) begin
                flag_word <= pwdata[15:0];
            end
            if (entry_last)
                pc_reg <= handler_addr;
            else if (state_reg == ST_RET_HI)
                pc_reg[15:0] <= mem_rdata;
            else if (state_reg == ST_RET_END)
                pc_reg[19:16] <= mem_rdata[15:12];
            else if (wr_en && hit_pc && in_run)
                pc_reg <= pwdata[19:0];
        end
    end

    // stack pointers move only after their pushes or pops
    wire sp_dn = entry_last;
    wire sp_up = state_reg == ST_RET_END;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isp_reg <= 16'h0000;
            usp_reg <= 16'h0000;
        end else begin
            if ((sp_dn || sp_up) && !u_flag)
                isp_reg <= sp_dn ? isp_reg - 16'h0004 : isp_reg + 16'h0004;
            else if (wr_en && hit_isp && in_run)
                isp_reg <= pwdata[15:0];
            if ((sp_dn || sp_up) && u_flag)
                usp_reg <= sp_dn ? usp_reg - 16'h0004 : usp_reg + 16'h0004;
            else if (wr_en && hit_usp && in_run)
                usp_reg <= pwdata[15:0];
        end
    end

    // pending bits: a request in the same cycle as a clear keeps the bit set
    wire [4:0] fixed_req = {addr_match_req, single_step_req, wdt_req, debugger_break_request,
        nmi_req};
    wire [4:0] fixed_ack = ack_info ? {src_reg == SRC_AM, src_reg == SRC_SS,
        src_reg == SRC_WDT, src_reg == SRC_BRK, src_reg == SRC_NMI} : 5'h00;
    genvar g;
    generate
        for (g = 0; g < NUM_PERIPH; g++) begin : g_pend
            wire ack_g = ack_info && src_reg == SRC_PERIPH && per_idx_reg == 8'(g);
            wire clr_g = (wr_en && hit_pend && !pwdata[g]) || ack_g;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    pend_reg[g] <= 1'b0;
                else
                    pend_reg[g] <= periph_req[g] | (pend_reg[g] & ~clr_g);
            end
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_pend_reg <= 5'h00;
            level_reg <= '0;
        end else begin
            fixed_pend_reg <= fixed_req | (fixed_pend_reg & ~fixed_ack
                & ~(wr_en && hit_pend ? ~pwdata[PEND_AM:PEND_NMI] : 5'h00));
            if (wr_en && hit_level)
                level_reg <= pwdata[3*NUM_PERIPH-1:0];
        end
    end

    // wait monitor: cycles from a pending candidate to the instruction boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 5'h00;
            max_wait_reg <= 5'h00;
            overrun_reg <= 1'b0;
        end else begin
            wait_reg <= (in_run && pick != SRC_NONE && !accept && wait_reg != 5'h1F)
                ? wait_reg + 5'h01 : 5'h00;
            if (wait_reg > max_wait_reg)
                max_wait_reg <= wait_reg;
            if (wait_reg > WAIT_MAX)
                overrun_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    info_read_first_a: assert property (accept |=> mem_re && mem_addr == INFO_ADDR)
        else $error("information read not first in entry");
    flags_cleared_a: assert property (accept && !take_swi |-> ##4 !i_flag && !u_flag)
        else $error("flags not cleared during entry");
    temp_saved_a: assert property (accept |-> ##3 temp_flag_reg == $past(flag_word, 3))
        else $error("temporary flag word mismatch");
    entry_even_a: assert property (accept && !bus_8bit && !vector_odd && !sp_odd
        && pick == SRC_PERIPH |-> ##18 handler_start)
        else $error("even entry not 18 cycles");
    nmi_level_a: assert property (handler_start && src_reg == SRC_NMI |=>
        processor_priority_level == PRIO_NMI_WDT)
        else $error("nmi did not load level 7");
    odd_bytes_a: assert property ($rose(mem_we) && sp_odd |-> mem_byte ##1
        (mem_we && mem_byte)[*3] ##1 !mem_we)
        else $error("odd stack pointer not written as four bytes");
    mask_gate_a: assert property (take_hw && pick == SRC_PERIPH |-> i_flag
        && best_lvl > processor_priority_level)
        else $error("masked peripheral accepted");
    nmi_first_a: assert property (fixed_pend_reg[0] && take_hw |-> pick == SRC_NMI)
        else $error("nmi lost arbitration");
    pend_ack_a: assert property (ack_info && src_reg == SRC_NMI && !nmi_req
        |=> !fixed_pend_reg[0])
        else $error("pending bit kept after acknowledge");
endmodule // interrupt_entry_sequencer
`default_nettype wire

/* File: verification/stack_mem_model.sv */
// behavioural stack and information memory facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module stack_mem_model (
    // clock
    input wire logic pclk,
    // memory bus driven by the sequencer
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic mem_byte,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    // read data, valid the cycle after a read strobe
    output logic [15:0] mem_rdata
);
    logic [7:0] mem [0:1023];
    logic [9:0] a;
    int nwr;
    // only the low 1 KiB is modelled, so the stacks are kept there
    assign a = mem_addr[9:0];
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        nwr = 0;
        mem_rdata = 16'h0000;
    end
    always @(posedge pclk) begin
        if (mem_we) begin
            mem[a] <= mem_wdata[7:0];
            nwr <= nwr + 1;
            if (!mem_byte) begin
                mem[a + 10'h001] <= mem_wdata[15:8];
            end
        end
        // data toggles outside a read so a late sample shows up
        if (mem_re) begin
            mem_rdata <= {mem[a + 10'h001], mem[a]};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // stack_mem_model
`default_nettype wire

/* File: verification/interrupt_entry_sequencer_tb.sv */
// self-checking bench for the interrupt entry sequencer
`timescale 1ns/1ns
`default_nettype none
module interrupt_entry_sequencer_tb;
    import irq_entry_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, periph_req;
    logic [31:0] pwdata, prdata, rdv;
    logic nmi_req, debugger_break_request, wdt_req, single_step_req, addr_match_req;
    logic instr_done, instr_busy, instr_suspendable, swi_exec, return_from_handler_instr;
    logic bus_8bit, vector_odd, mem_we, mem_re, mem_byte, handler_start;
    logic [5:0] swi_num;
    logic [19:0] handler_addr, mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    src_t accepted_src;
    logic [2:0] processor_priority_level;
    int n_mismatch, compares;

    interrupt_entry_sequencer #(.NUM_PERIPH(8)) DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .periph_req, .nmi_req,
        .debugger_break_request, .wdt_req, .single_step_req, .addr_match_req, .instr_done,
        .instr_busy, .instr_suspendable, .swi_exec, .swi_num, .return_from_handler_instr,
        .bus_8bit, .vector_odd, .handler_addr, .mem_we, .mem_re, .mem_byte, .mem_addr,
        .mem_wdata, .mem_rdata, .handler_start, .accepted_src, .processor_priority_level);
    stack_mem_model mem_model (.pclk, .mem_we, .mem_re, .mem_byte, .mem_addr, .mem_wdata,
        .mem_rdata);

    always #5 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // f holds {match, step, watchdog, break, nmi}
    task automatic req(input logic [7:0] p, input logic [4:0] f);
        periph_req <= p;
        {addr_match_req, single_step_req, wdt_req, debugger_break_request, nmi_req} <= f;
        @(posedge pclk);
        periph_req <= 8'h00;
        {addr_match_req, single_step_req, wdt_req, debugger_break_request, nmi_req} <= 5'h00;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] word(input logic [9:0] a);
        return {16'h0000, mem_model.mem[a + 10'h001], mem_model.mem[a]};
    endfunction

    // cycles are counted from the accepting edge to the handler start pulse
    task automatic run_entry(input logic by_done, input int cyc, input src_t s,
        input logic [2:0] lvl);
        int n;
        instr_done <= by_done;
        @(posedge pclk);
        instr_done <= 1'b0;
        swi_exec <= 1'b0;
        n = 0;
        while (handler_start !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40) begin
            n_mismatch++;
            report_and_stop();
        end
        check(n, cyc);
        repeat (2) @(posedge pclk);
        check({29'h0, accepted_src}, {29'h0, s});
        check({29'h0, processor_priority_level}, {29'h0, lvl});
    endtask

    task automatic s_reset();
        rd(ADDR_FLAG);
        check(rdv, {16'h0000, FLAG_RESET});
        rd(8'h40);
        check({31'h0, err}, 32'h0000_0001);
    endtask

    task automatic s_periph();
        int w0;
        wr(ADDR_ISP, 32'h0000_0100);
        wr(ADDR_PC, 32'h0005_ABCD);
        wr(ADDR_FLAG, 32'h0000_20C4);
        wr(ADDR_LEVEL, 32'h0000_0A28);
        w0 = mem_model.nwr;
        req(8'h0A, 5'h08);
        run_entry(1'b1, 18, SRC_PERIPH, 3'h5);
        check(mem_model.nwr - w0, 2);
        rd(ADDR_TIMING);
        check({27'h0, rdv[14:10]}, 32'h0000_0012);
        check(word(10'h0FE), 32'h0000_52C4);
        check(word(10'h0FC), 32'h0000_ABCD);
        rd(ADDR_ISP);
        check(rdv, 32'h0000_00FC);
        rd(ADDR_FLAG);
        check(rdv, 32'h0000_5000);
        rd(ADDR_PC);
        check(rdv, 32'h0001_2340);
        // the single-step request stays pending with no boundary, so the wait monitor overruns
        repeat (32) @(posedge pclk);
        rd(ADDR_STATUS);
        check({24'h0, rdv[31:24]}, 32'h0000_0001);
        check({31'h0, rdv[7]}, 32'h0000_0001);
        rd(ADDR_PEND);
        check(rdv, 32'h0008_0008);
        wr(ADDR_PEND, 32'h0000_0000);
        wr(ADDR_PEND, 32'hFFFF_FFFF);
        rd(ADDR_PEND);
        check(rdv, 32'h0000_0000);
        return_from_handler_instr <= 1'b1;
        @(posedge pclk);
        return_from_handler_instr <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(ADDR_FLAG);
        check(rdv, 32'h0000_20C4);
        rd(ADDR_PC);
        check(rdv, 32'h0005_ABCD);
        rd(ADDR_ISP);
        check(rdv, 32'h0000_0100);
    endtask

    task automatic s_odd();
        int w0;
        wr(ADDR_FLAG, 32'h0000_0000);
        wr(ADDR_ISP, 32'h0000_0101);
        vector_odd <= 1'b1;
        w0 = mem_model.nwr;
        req(8'h00, 5'h05);
        run_entry(1'b1, 20, SRC_NMI, 3'h7);
        check(mem_model.nwr - w0, 4);
        check(word(10'h0FF), 32'h0000_5000);
        check(word(10'h0FD), 32'h0000_ABCD);
        vector_odd <= 1'b0;
        run_entry(1'b1, 19, SRC_WDT, 3'h7);
    endtask

    task automatic s_brk();
        wr(ADDR_ISP, 32'h0000_0100);
        wr(ADDR_FLAG, 32'h0000_3000);
        bus_8bit <= 1'b1;
        req(8'h00, 5'h12);
        run_entry(1'b1, 22, SRC_BRK, 3'h3);
        bus_8bit <= 1'b0;
        run_entry(1'b1, 19, SRC_AM, 3'h3);
    endtask

    task automatic s_mask();
        int hits;
        wr(ADDR_FLAG, 32'h0000_5040);
        wr(ADDR_LEVEL, 32'h0000_0005);
        req(8'h05, 5'h00);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        hits = 0;
        repeat (25) begin
            @(posedge pclk);
            if (handler_start !== 1'b0) hits++;
        end
        check(hits, 0);
        wr(ADDR_FLAG, 32'h0000_4040);
        run_entry(1'b1, 18, SRC_PERIPH, 3'h5);
        rd(ADDR_PEND);
        check(rdv, 32'h0000_0004);
        wr(ADDR_PEND, 32'h0000_0000);
    endtask

    task automatic s_susp();
        wr(ADDR_FLAG, 32'h0000_0040);
        wr(ADDR_LEVEL, 32'h0000_0001);
        req(8'h01, 5'h00);
        instr_busy <= 1'b1;
        instr_suspendable <= 1'b1;
        run_entry(1'b0, 18, SRC_PERIPH, 3'h1);
        instr_busy <= 1'b0;
        instr_suspendable <= 1'b0;
    endtask

    task automatic s_swi();
        logic [5:0] nums [3] = '{6'h1F, 6'h20, 6'h3F};
        logic kept;
        foreach (nums[i]) begin
            wr(ADDR_FLAG, 32'h0000_70C0);
            wr(ADDR_ISP, 32'h0000_0100);
            wr(ADDR_USP, 32'h0000_0200);
            swi_num <= nums[i];
            swi_exec <= 1'b1;
            run_entry(1'b0, 18, SRC_SWI, 3'h7);
            kept = (nums[i] >= 6'h20);
            rd(ADDR_USP);
            check(rdv, kept ? 32'h0000_01FC : 32'h0000_0200);
            rd(ADDR_FLAG);
            check(rdv, kept ? 32'h0000_7080 : 32'h0000_7000);
        end
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, instr_done, instr_busy} = 7'h00;
        {instr_suspendable, swi_exec, return_from_handler_instr, bus_8bit} = 4'h0;
        {nmi_req, debugger_break_request, wdt_req, single_step_req, addr_match_req} = 5'h00;
        {vector_odd, paddr, periph_req, swi_num} = 23'h000000;
        pwdata = 32'h0000_0000;
        handler_addr = 20'h12340;
        n_mismatch = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_periph();
        s_odd();
        s_brk();
        s_mask();
        s_susp();
        s_swi();
        report_and_stop();
    end
endmodule // interrupt_entry_sequencer_tb
`default_nettype wire
